// ==== blscr_defs.svh ====
// register offsets, field positions, reset values and decode constants for the backlight register bank
`ifndef BLSCR_DEFS_SVH
`define BLSCR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define BLSCR_OFS_FLAGS        8'h02
`define BLSCR_OFS_ID           8'h03
`define BLSCR_OFS_DC_LEVEL     8'h07
`define BLSCR_OFS_OPTIONS      8'h08

// ****************************************
// reset values
// ****************************************
`define BLSCR_RST_FLAGS        8'h00
`define BLSCR_RST_DC_LEVEL     8'hff
`define BLSCR_RST_OPTIONS      8'h1f

// ****************************************
// fault and state flag positions
// ****************************************
`define BLSCR_BIT_SUMMARY      0
`define BLSCR_BIT_OVERTEMP     1
`define BLSCR_BIT_OVERCURRENT  2
`define BLSCR_BIT_BL_ON        3
`define BLSCR_BIT_ONE_DOWN     4
`define BLSCR_BIT_TWO_DOWN     5

// ****************************************
// identification register layout
// ****************************************
`define BLSCR_ID_TOP_BIT       1'h1
`define BLSCR_DEF_MAKER        4'hf // arbitrary value
`define BLSCR_DEF_REVISION     3'h0

// ****************************************
// driver option field positions
// ****************************************
`define BLSCR_BIT_PLL_BYPASS   7
`define BLSCR_BIT_PASSTHROUGH  6
`define BLSCR_BIT_DUTY_LEVEL   5
`define BLSCR_POS_DRIVE_HI     4
`define BLSCR_POS_DRIVE_LO     3
`define BLSCR_BIT_FSW          2
`define BLSCR_POS_SHORT_HI     1
`define BLSCR_POS_SHORT_LO     0

// ****************************************
// decode constants
// ****************************************
`define BLSCR_CHANNELS         6
`define BLSCR_FSW_FAST_KHZ     1200
`define BLSCR_FSW_SLOW_KHZ     600
`define BLSCR_BYPASS_MAX_KHZ   30

`endif

// ==== blscr_pkg.sv ====
// types shared by the backlight register bank modules
package blscr_pkg;

	// boost switch driver strength, quarter steps
	typedef enum logic [1:0]
	{
		BLSCR_DRIVE_25,
		BLSCR_DRIVE_50,
		BLSCR_DRIVE_75,
		BLSCR_DRIVE_100
	} blscr_drive_t;

	// channel short-circuit detection threshold
	typedef enum logic [1:0]
	{
		BLSCR_SHORT_OFF,
		BLSCR_SHORT_3V6,
		BLSCR_SHORT_4V8,
		BLSCR_SHORT_5V8
	} blscr_short_t;

	// how the channel current sources are gated
	typedef enum logic [1:0]
	{
		BLSCR_GATE_REGISTER_PWM,
		BLSCR_GATE_DIRECT,
		BLSCR_GATE_DC_FROM_DUTY
	} blscr_gate_t;

endpackage

// ==== blscr_chan_count.sv ====
// counts faulted-out channels into one-down and two-down levels
module blscr_chan_count
	import blscr_pkg::*;
#(
	parameter int CHANNELS = 6
)
(
	input  wire logic [CHANNELS-1:0] chan_fault_i,
	output logic                     one_down_o,
	output logic                     two_down_o
);

	// ****************************************
	// population count
	// ****************************************
	logic [3:0] count;

	// saturating count of faulted channels
	always_comb
	begin
		count = 4'h0;
		for (int i = 0; i < CHANNELS; i++)
		begin
			if (chan_fault_i[i] && count != 4'hf)
				count = count + 4'h1;
		end
	end

	assign one_down_o = (count >= 4'h1);
	assign two_down_o = (count >= 4'h2);

endmodule

// ==== blscr_option_decode.sv ====
// decodes the driver option byte into analog control selects
`include "blscr_defs.svh"
module blscr_option_decode
	import blscr_pkg::*;
(
	input  wire logic [7:0] options_i,
	output logic            pll_bypass_o,
	output blscr_gate_t     gate_mode_o,
	output blscr_drive_t    boost_drive_strength_o,
	output logic            fsw_slow_o,
	output logic [10:0]     fsw_khz_o,
	output blscr_short_t    short_threshold_o,
	output logic            short_detect_en_o
);

	// ****************************************
	// option decode
	// ****************************************

	// pll bypass hands the dimming rate to the resistor pin
	assign pll_bypass_o = options_i[`BLSCR_BIT_PLL_BYPASS];

	// passthrough takes priority: both set would fight over the sources
	always_comb
	begin
		if (options_i[`BLSCR_BIT_PASSTHROUGH])
			gate_mode_o = BLSCR_GATE_DIRECT;
		else if (options_i[`BLSCR_BIT_DUTY_LEVEL])
			gate_mode_o = BLSCR_GATE_DC_FROM_DUTY;
		else
			gate_mode_o = BLSCR_GATE_REGISTER_PWM;
	end

	// two-bit strength field straight onto the enum
	assign boost_drive_strength_o =
		blscr_drive_t'(options_i[`BLSCR_POS_DRIVE_HI:`BLSCR_POS_DRIVE_LO]);

	// 0 selects the fast switching rate
	assign fsw_slow_o = options_i[`BLSCR_BIT_FSW];
	assign fsw_khz_o  = fsw_slow_o ? 11'(`BLSCR_FSW_SLOW_KHZ)
		: 11'(`BLSCR_FSW_FAST_KHZ);

	// code 0 disables detection entirely
	assign short_threshold_o =
		blscr_short_t'(options_i[`BLSCR_POS_SHORT_HI:`BLSCR_POS_SHORT_LO]);
	assign short_detect_en_o = (short_threshold_o != BLSCR_SHORT_OFF);

endmodule

// ==== blscr_regs.sv ====
// register bank of the backlight controller: status flags, id, dc level and driver options
//
// Summary of operation
// - summary flag ORs all four fault conditions
// - summary flag stays set once set
// - backlight toggle or host zero clears summary
// - backlight-on never sets the summary flag
// - one-down flag when any channel faulted
// - two-down flag when two channels faulted
// - brief on-then-off pulse records no fault
// - only summary bit writable, upper bits zero
// - status register resets to zero
// - status bit layout as documented
// - id: top bit one, maker, revision
// - revision starts at zero, then increments
// - maker codes: others, reserved, fifteen none
// - dc level linear, applied on the fly
// - dc write touches only dc level
// - dc level resets to all ones
// - pll bypass selects resistor dimming rate
// - passthrough gates sources from pwm input
// - duty-to-level keeps sources on, dc level
// - two-bit field picks boost drive strength
// - switching select picks boost frequency
// - short field picks threshold or disable
// - options register resets to default pattern
// - backlight request bit on/off, resets zero
// - switching select 0 fast, 1 slow
// - short codes: off, 3.6, 4.8, 5.8
`include "blscr_defs.svh"
module blscr_regs
	import blscr_pkg::*;
#(
	parameter int         CHANNELS      = `BLSCR_CHANNELS,
	parameter logic [3:0] MAKER_CODE    = `BLSCR_DEF_MAKER,    // arbitrary value
	parameter logic [2:0] SILICON_REV   = `BLSCR_DEF_REVISION,
	parameter int         ARM_DELAY_CYC = 4
)
(
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                wr_en_i,
	input  wire logic                rd_en_i,
	input  wire logic [7:0]          addr_i,
	input  wire logic [7:0]          wr_data_i,
	output logic [7:0]               rd_data_o,
	output logic                     rd_valid_o,
	input  wire logic                backlight_on_request_i,
	input  wire logic                backlight_is_lit_i,
	input  wire logic                overtemp_i,
	input  wire logic                input_overcurrent_i,
	input  wire logic [CHANNELS-1:0] chan_fault_i,
	output logic [7:0]               dc_level_code_o,
	output logic                     pll_bypass_o,
	output blscr_gate_t              gate_mode_o,
	output blscr_drive_t             boost_drive_strength_o,
	output logic                     fsw_slow_o,
	output logic [10:0]              fsw_khz_o,
	output blscr_short_t             short_threshold_o,
	output logic                     short_detect_en_o
);

	// ****************************************
	// channel fault levels
	// ****************************************
	logic single_channel_down_flag;
	logic multi_channel_down_flag;

	blscr_chan_count #(
		.CHANNELS (CHANNELS)
	) u_chan_count (
		.chan_fault_i (chan_fault_i),
		.one_down_o   (single_channel_down_flag),
		.two_down_o   (multi_channel_down_flag)
	);

	// ****************************************
	// state
	// ****************************************
	logic       fault_summary;
	logic       overtemp_flag;
	logic       input_overcurrent_flag;
	logic       backlight_on_flag;
	logic       one_down_q;
	logic       two_down_q;
	logic       request_q;
	logic [2:0] arm_count;
	logic [7:0] dc_current_level;
	logic [7:0] driver_options;
	logic [7:0] rd_data;
	logic       rd_valid;

	logic       next_fault_summary;
	logic       next_overtemp_flag;
	logic       next_input_overcurrent_flag;
	logic       next_backlight_on_flag;
	logic       next_one_down_q;
	logic       next_two_down_q;
	logic       next_request_q;
	logic [2:0] next_arm_count;
	logic [7:0] next_dc_current_level;
	logic [7:0] next_driver_options;
	logic [7:0] next_rd_data;
	logic       next_rd_valid;

	// ****************************************
	// fault qualification
	// ****************************************
	logic request_toggled;
	logic fault_armed;
	logic any_fault;
	logic host_clears_summary;

	// either edge of the host request counts as a toggle
	assign request_toggled = backlight_on_request_i ^ request_q;

	// faults only count once the light has been commanded on for a few cycles, so a
	// short on-then-off command never latches a spurious fault
	assign fault_armed = backlight_on_request_i
		&& (arm_count == 3'(ARM_DELAY_CYC));

	// backlight-on is deliberately absent from this OR
	assign any_fault = overtemp_i | input_overcurrent_i
		| single_channel_down_flag | multi_channel_down_flag;

	assign host_clears_summary = wr_en_i && (addr_i == `BLSCR_OFS_FLAGS)
		&& !wr_data_i[`BLSCR_BIT_SUMMARY];

	// ****************************************
	// status and arming next state
	// ****************************************
	always_comb
	begin
		next_request_q              = backlight_on_request_i;
		next_overtemp_flag          = overtemp_i;
		next_input_overcurrent_flag = input_overcurrent_i;
		next_one_down_q             = single_channel_down_flag;
		next_two_down_q             = multi_channel_down_flag;
		next_backlight_on_flag      = backlight_is_lit_i;
		next_arm_count              = arm_count;
		next_fault_summary          = fault_summary;

		// arm counter restarts whenever the light is commanded off
		if (!backlight_on_request_i || request_toggled)
			next_arm_count = 3'h0;
		else if (arm_count != 3'(ARM_DELAY_CYC))
			next_arm_count = arm_count + 3'h1;

		// clear first, then a live fault sets again in the same cycle
		if (request_toggled || host_clears_summary)
			next_fault_summary = 1'b0;
		if (any_fault && fault_armed)
			next_fault_summary = 1'b1;
	end

	// ****************************************
	// writable registers next state
	// ****************************************
	always_comb
	begin
		next_dc_current_level = dc_current_level;
		next_driver_options   = driver_options;
		// id bits have no storage; a status write only clears the summary, above
		if (wr_en_i)
		begin
			unique case (addr_i)
				`BLSCR_OFS_DC_LEVEL: next_dc_current_level = wr_data_i;
				`BLSCR_OFS_OPTIONS:  next_driver_options   = wr_data_i;
				default:             ;
			endcase
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb
	begin
		next_rd_data  = rd_data;
		next_rd_valid = rd_en_i;
		if (rd_en_i)
		begin
			unique case (addr_i)
				`BLSCR_OFS_FLAGS: next_rd_data = {2'b00, two_down_q, one_down_q,
					backlight_on_flag, input_overcurrent_flag, overtemp_flag,
					fault_summary};
				`BLSCR_OFS_ID: next_rd_data = {`BLSCR_ID_TOP_BIT, MAKER_CODE,
					SILICON_REV};
				`BLSCR_OFS_DC_LEVEL: next_rd_data = dc_current_level;
				`BLSCR_OFS_OPTIONS:  next_rd_data = driver_options;
				default:             next_rd_data = 8'h00;
			endcase
		end
	end

	// ****************************************
	// option decode
	// ****************************************
	localparam logic [7:0] RST_OPTS = `BLSCR_RST_OPTIONS;

	logic         next_pll_bypass;
	blscr_gate_t  next_gate_mode;
	blscr_drive_t next_boost_drive_strength;
	logic         next_fsw_slow;
	logic [10:0]  next_fsw_khz;
	blscr_short_t next_short_threshold;
	logic         next_short_detect_en;
	logic         pll_bypass;
	blscr_gate_t  gate_mode;
	blscr_drive_t boost_drive_strength;
	logic         fsw_slow;
	logic [10:0]  fsw_khz;
	blscr_short_t short_threshold;
	logic         short_detect_en;

	// decode the byte about to be stored, so the registered selects move on
	// the same edge as the option byte and never glitch into the analog side
	blscr_option_decode u_option_decode (
		.options_i              (next_driver_options),
		.pll_bypass_o           (next_pll_bypass),
		.gate_mode_o            (next_gate_mode),
		.boost_drive_strength_o (next_boost_drive_strength),
		.fsw_slow_o             (next_fsw_slow),
		.fsw_khz_o              (next_fsw_khz),
		.short_threshold_o      (next_short_threshold),
		.short_detect_en_o      (next_short_detect_en)
	);

	// ****************************************
	// status registers
	// ****************************************

	// live flags lag their inputs by one cycle, the summary alone is sticky
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			fault_summary          <= 1'b0;
			overtemp_flag          <= 1'b0;
			input_overcurrent_flag <= 1'b0;
			backlight_on_flag      <= 1'b0;
			one_down_q             <= 1'b0;
			two_down_q             <= 1'b0;
			request_q              <= 1'b0;
			arm_count              <= 3'h0;
		end
		else
		begin
			fault_summary          <= next_fault_summary;
			overtemp_flag          <= next_overtemp_flag;
			input_overcurrent_flag <= next_input_overcurrent_flag;
			backlight_on_flag      <= next_backlight_on_flag;
			one_down_q             <= next_one_down_q;
			two_down_q             <= next_two_down_q;
			request_q              <= next_request_q;
			arm_count              <= next_arm_count;
		end
	end

	// ****************************************
	// writable registers
	// ****************************************

	// only the dc level and the option byte hold host-written state
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dc_current_level <= `BLSCR_RST_DC_LEVEL;
			driver_options   <= `BLSCR_RST_OPTIONS;
		end
		else
		begin
			dc_current_level <= next_dc_current_level;
			driver_options   <= next_driver_options;
		end
	end

	// ****************************************
	// read answer registers
	// ****************************************

	// read data holds between reads, valid is a one-cycle pulse
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_data  <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	// ****************************************
	// decoded select registers
	// ****************************************

	// gate, rate and enable reset values are written out by hand: they must
	// track the reset option byte if that ever changes
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pll_bypass           <= RST_OPTS[`BLSCR_BIT_PLL_BYPASS];
			gate_mode            <= BLSCR_GATE_REGISTER_PWM;
			boost_drive_strength <=
				blscr_drive_t'(RST_OPTS[`BLSCR_POS_DRIVE_HI:`BLSCR_POS_DRIVE_LO]);
			fsw_slow             <= RST_OPTS[`BLSCR_BIT_FSW];
			fsw_khz              <= 11'(`BLSCR_FSW_SLOW_KHZ);
			short_threshold      <=
				blscr_short_t'(RST_OPTS[`BLSCR_POS_SHORT_HI:`BLSCR_POS_SHORT_LO]);
			short_detect_en      <= 1'b1;
		end
		else
		begin
			pll_bypass           <= next_pll_bypass;
			gate_mode            <= next_gate_mode;
			boost_drive_strength <= next_boost_drive_strength;
			fsw_slow             <= next_fsw_slow;
			fsw_khz              <= next_fsw_khz;
			short_threshold      <= next_short_threshold;
			short_detect_en      <= next_short_detect_en;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// dc level goes straight to the current dac, so changes apply on the fly
	assign dc_level_code_o        = dc_current_level;
	assign rd_data_o              = rd_data;
	assign rd_valid_o             = rd_valid;
	assign pll_bypass_o           = pll_bypass;
	assign gate_mode_o            = gate_mode;
	assign boost_drive_strength_o = boost_drive_strength;
	assign fsw_slow_o             = fsw_slow;
	assign fsw_khz_o              = fsw_khz;
	assign short_threshold_o      = short_threshold;
	assign short_detect_en_o      = short_detect_en;

endmodule

// ==== blscr_regs_asserts.sv ====
// concurrent checks on the port behaviour of the backlight register bank
module blscr_regs_checker
	import blscr_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         wr_en_i,
	input  wire logic         rd_en_i,
	input  wire logic [7:0]   addr_i,
	input  wire logic [7:0]   wr_data_i,
	input  wire logic [7:0]   rd_data_o,
	input  wire logic         rd_valid_o,
	input  wire logic [7:0]   dc_level_code_o,
	input  wire logic         pll_bypass_o,
	input  wire blscr_gate_t  gate_mode_o,
	input  wire blscr_drive_t boost_drive_strength_o,
	input  wire logic         fsw_slow_o,
	input  wire logic [10:0]  fsw_khz_o,
	input  wire blscr_short_t short_threshold_o,
	input  wire logic         short_detect_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ****************************************
	// register access
	// ****************************************
	AST_RD_ANSWER: assert property (rd_en_i |=> rd_valid_o)
		else $error("read answer missing");
	AST_RD_ONLY: assert property (rd_valid_o |-> $past(rd_en_i))
		else $error("read answer without request");
	AST_DC_WRITE: assert property (wr_en_i && addr_i == 8'h07 |=> dc_level_code_o == $past(wr_data_i))
		else $error("dc level not taken");
	AST_DC_HOLD: assert property (!(wr_en_i && addr_i == 8'h07) |=> $stable(dc_level_code_o))
		else $error("dc level changed without write");
	AST_STATUS_TOP: assert property (rd_en_i && addr_i == 8'h02 |=> rd_data_o[7:6] == 2'b00)
		else $error("status upper bits set");
	AST_ID_TOP: assert property (rd_en_i && addr_i == 8'h03 |=> rd_data_o[7])
		else $error("id top bit clear");
	// ****************************************
	// option decode
	// ****************************************
	AST_OPT_WRITE: assert property (wr_en_i && addr_i == 8'h08 |=> {pll_bypass_o, boost_drive_strength_o,
		fsw_slow_o, short_threshold_o} == {$past(wr_data_i[7]), $past(wr_data_i[4:0])})
		else $error("option fields not taken");
	AST_GATE: assert property (wr_en_i && addr_i == 8'h08 |=> gate_mode_o == ($past(wr_data_i[6]) ?
		BLSCR_GATE_DIRECT : $past(wr_data_i[5]) ? BLSCR_GATE_DC_FROM_DUTY : BLSCR_GATE_REGISTER_PWM))
		else $error("gate mode wrong");
	AST_FSW: assert property (fsw_khz_o == (fsw_slow_o ? 11'd600 : 11'd1200))
		else $error("switching rate wrong");
	AST_SHORT_EN: assert property (short_detect_en_o == (short_threshold_o != BLSCR_SHORT_OFF))
		else $error("short detect enable wrong");
endmodule

// ==== blscr_host.sv ====
// host model issuing single byte reads and writes to the register bank
module blscr_host
(
	input  wire logic       clk_i,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wr_data_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial
	begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wr_data_o = 8'h00;
	end
	// one write byte; idle lines get inverted so stale values never look valid
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wr_data_o <= d;
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		addr_o <= ~a;
		wr_data_o <= ~d;
	endtask
	// one read byte; answer taken mid-cycle while the one-cycle valid stands
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rd_data_i;
		v = rd_valid_i;
	endtask
endmodule

// ==== blscr_regs_bench.sv ====
// self-checking bench for the backlight register bank
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module blscr_regs_bench
	import blscr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, wr_en, rd_en, lit, req, otemp, ocur, rd_valid;
	logic [7:0] addr, wr_data, rd_data, dc, d;
	logic [5:0] chan;
	logic pll, fsw_slow, sen;
	logic [10:0] khz;
	blscr_gate_t gate;
	blscr_drive_t drv;
	blscr_short_t sthr;
	int fails = 0;
	int samples_checked = 0;
	logic [7:0] opts [4] = '{8'h00, 8'h6b, 8'hb6, 8'hdd};
	// maker code is an arbitrary neutral value
	blscr_regs #(.MAKER_CODE(4'h5), .SILICON_REV(3'h0), .ARM_DELAY_CYC(4)) dut (.clk_i(clk),
		.reset_n_i(reset_n), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wr_data),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .backlight_on_request_i(req),
		.backlight_is_lit_i(lit), .overtemp_i(otemp), .input_overcurrent_i(ocur),
		.chan_fault_i(chan), .dc_level_code_o(dc), .pll_bypass_o(pll), .gate_mode_o(gate),
		.boost_drive_strength_o(drv), .fsw_slow_o(fsw_slow), .fsw_khz_o(khz),
		.short_threshold_o(sthr), .short_detect_en_o(sen));
	blscr_host host (.clk_i(clk), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
		.wr_data_o(wr_data), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
	// ****************************************
	// helpers
	// ****************************************
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic v;
		host.read_byte(a, d, v);
		`CHK("rd_valid", 1'b1, v)
		`CHK("rd_data", e, d)
	endtask
	// drive fault inputs, then let flags and summary settle
	task automatic fault(input logic r, input logic t, input logic c, input logic [5:0] ch);
		@(posedge clk);
		req <= r;
		otemp <= t;
		ocur <= c;
		chan <= ch;
		repeat (8) @(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog, well beyond the two hundred or so cycles the tests need
	initial
	begin
		#2000000;
		fails++;
		tally_and_finish();
	end
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		{reset_n, lit, req, otemp, ocur, chan} = '0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h02, 8'h00);
		rd(8'h03, 8'ha8);
		rd(8'h07, 8'hff);
		rd(8'h08, 8'h1f);
		rd(8'h10, 8'h00);
		$display("test reset done");
		foreach (opts[i])
		begin
			host.write_byte(8'h07, opts[i]);
			rd(8'h07, opts[i]);
			`CHK("dc_level", opts[i], dc)
			host.write_byte(8'h08, opts[i]);
			rd(8'h08, opts[i]);
			`CHK("drive", opts[i][4:3], drv)
			`CHK("khz", opts[i][2] ? 11'd600 : 11'd1200, khz)
			`CHK("short", opts[i][1:0], sthr)
			`CHK("bypass", opts[i][7], pll)
		end
		host.write_byte(8'h03, 8'h00);
		host.write_byte(8'h02, 8'hff);
		rd(8'h03, 8'ha8);
		rd(8'h02, 8'h00);
		rd(8'h08, 8'hdd);
		$display("test registers done");
		fault(1'b1, 1'b1, 1'b0, 6'h00);
		rd(8'h02, 8'h03);
		fault(1'b1, 1'b0, 1'b0, 6'h00);
		rd(8'h02, 8'h01);
		host.write_byte(8'h02, 8'hff);
		rd(8'h02, 8'h01);
		host.write_byte(8'h02, 8'h00);
		rd(8'h02, 8'h00);
		fault(1'b1, 1'b0, 1'b1, 6'h00);
		host.write_byte(8'h02, 8'h00);
		rd(8'h02, 8'h05);
		fault(1'b1, 1'b0, 1'b0, 6'h04);
		rd(8'h02, 8'h11);
		fault(1'b1, 1'b0, 1'b0, 6'h24);
		rd(8'h02, 8'h31);
		fault(1'b0, 1'b0, 1'b0, 6'h00);
		rd(8'h02, 8'h00);
		@(posedge clk);
		lit <= 1'b1;
		fault(1'b1, 1'b0, 1'b0, 6'h00);
		rd(8'h02, 8'h08);
		@(posedge clk);
		lit <= 1'b0;
		fault(1'b0, 1'b1, 1'b0, 6'h00);
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h02, 8'h02);
		$display("test faults done");
		tally_and_finish();
	end
endmodule
bind blscr_regs blscr_regs_checker chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en_i),
	.rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .dc_level_code_o(dc_level_code_o), .pll_bypass_o(pll_bypass_o),
	.gate_mode_o(gate_mode_o), .boost_drive_strength_o(boost_drive_strength_o),
	.fsw_slow_o(fsw_slow_o), .fsw_khz_o(fsw_khz_o), .short_threshold_o(short_threshold_o),
	.short_detect_en_o(short_detect_en_o));
